// ==== src/insd_core.sv ====
// Instruction classification, synchronization and exception routing block.
// Assumes an APB master on pclk, and core status inputs on the same clock.
// Functional notes
// [RQ1] Service call and interrupt return wait for older instructions before switching.
// [RQ2] Service call executes only with no higher-priority exception pending.
// [RQ3] Context sync waits until older work cannot fault and store errors resolve.
// [RQ4] Older instructions finish under the privilege in force at their issue.
// [RQ5] Following instructions use the context the sync instruction established.
// [RQ6] Execution sync waits before start; barriers wait before completing.
// [RQ7] Machine state write waits for older work; later ones keep old state.
// [RQ8] New user mode is enforced only after an instruction barrier; here interrupt return also loads the enforced user mode bit directly.
// [RQ9] Illegal encodings raise the illegal-instruction program exception.
// [RQ10] Supervisor instructions in user mode raise privileged program exception.
// [RQ11] Special register moves are privileged by the encoded register number.
// [RQ12] Unavailable memory raises the instruction access fault.
// [RQ13] Disallowed effective address alignment raises the alignment exception.
// [RQ14] Service call always raises the system call exception.
// [RQ15] Trap with met condition raises trap program exception.
// [RQ16] Floating-point work while unavailable raises floating-point unavailable.
// [RQ17] Enabled floating-point exception raises a program exception.
// [RQ18] Record form updates the condition register; plain form does not.
// [RQ19] Overflow form updates the overflow bit of the exception register.
// [RQ20] Subtract-from computes third operand minus second.
// [RQ21] Register and immediate compares signed; logical compares unsigned.
// [RQ22] Compare writes the selected field; field zero when omitted.
// [RQ23] Integer arithmetic uses 32-bit two's-complement semantics.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "insd_defines.svh"
module insd_core import insd_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        older_busy,
	input  wire logic        dstore_err_pend,
	input  wire logic        hi_prio_pend,
	input  wire logic        page_fault,
	input  wire logic        fp_exc_raised,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             exc_valid,
	output logic      [3:0]  exc_class,
	output logic             ctx_sync,
	output logic             user_mode_bit
);
	insd_state_e state_q;
	logic [31:0] insn_q;
	logic [31:0] opa_q;
	logic [31:0] opb_q;
	logic [31:0] machine_state_reg_q;
	logic [31:0] integer_exception_reg_q;
	logic [31:0] condition_reg_q;
	logic [31:0] result_q;
	logic        rd_sel;
	logic        wr_go;
	logic        map_hit;
	logic        ro_hit;
	logic [5:0]  op6;
	logic [9:0]  xo10;
	logic [8:0]  xo9;
	logic [31:0] simm;
	logic [31:0] base_a;
	logic [31:0] opnd_b;
	logic [31:0] ea;
	logic        is_fp;
	insd_exc_e   d_cls;
	insd_alu_e   d_alu;
	logic [1:0]  d_bsel;
	logic        d_ill, d_priv, d_arith, d_setca, d_oe, d_rc, d_cmp, d_cmps;
	logic        d_mem, d_trap, d_pre, d_post, d_svc, d_retint, d_mtms;
	logic        d_ibar, d_mfms, d_fp, d_zra;
	logic [1:0]  d_size;
	logic        misalign;
	logic        trap_hit;
	logic        drained;
	logic        apply;
	logic [31:0] alu_res;
	logic        alu_ca;
	logic        alu_ov;
	logic        so_next;
	logic [3:0]  cmp_field;
	logic [3:0]  rec_field;
	logic [2:0]  tgt_fld;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign rd_sel  = psel && penable && !pready;
	assign wr_go   = psel && penable && pready && pwrite && !pslverr;
	assign map_hit = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
	assign ro_hit  = (paddr == `INSD_OFF_RESULT) || (paddr == `INSD_OFF_STATUS);

	// One wait state: pready the cycle after access starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `INSD_RST_WORD;
		end else begin
			pready  <= rd_sel;
			pslverr <= rd_sel && (!map_hit || (pwrite && ro_hit) ||
			           (pwrite && paddr == `INSD_OFF_INSN && state_q != ST_IDLE));
			if (rd_sel && !pwrite) begin
				case (paddr)
					`INSD_OFF_INSN:   prdata <= insn_q;
					`INSD_OFF_OPA:    prdata <= opa_q;
					`INSD_OFF_OPB:    prdata <= opb_q;
					`INSD_OFF_MSTATE: prdata <= machine_state_reg_q;
					`INSD_OFF_INTEXC: prdata <= integer_exception_reg_q;
					`INSD_OFF_COND:   prdata <= condition_reg_q;
					`INSD_OFF_RESULT: prdata <= result_q;
					`INSD_OFF_STATUS: prdata <= {22'h000000, user_mode_bit,
					                   state_q != ST_IDLE, exc_valid, 3'h0, exc_class};
					default:          prdata <= `INSD_RST_WORD;
				endcase
			end
		end
	end

	// Operand registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_q <= `INSD_RST_WORD;
			opb_q <= `INSD_RST_WORD;
		end else if (wr_go) begin
			if (paddr == `INSD_OFF_OPA) opa_q <= pwdata;
			if (paddr == `INSD_OFF_OPB) opb_q <= pwdata;
		end
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign op6    = insn_q[31:26];
	assign xo10   = insn_q[10:1];
	assign xo9    = insn_q[9:1];
	assign simm   = {{16{insn_q[15]}}, insn_q[15:0]};
	assign is_fp  = (op6 == `INSD_OP_FPS) || (op6 == `INSD_OP_FPD) ||
	                (op6 >= `INSD_OP_FPM_LO && op6 <= `INSD_OP_FPM_HI);
	assign base_a = (d_zra && insn_q[20:16] == 5'h00) ? 32'h0000_0000 : opa_q;
	assign tgt_fld = insn_q[25:23];

	// Class and control flags of the held instruction
	always_comb begin
		d_alu = ALU_ADD; d_bsel = 2'd0; d_size = 2'd0;
		d_ill = 1'b0; d_priv = 1'b0; d_arith = 1'b0; d_setca = 1'b0; d_oe = 1'b0;
		d_rc = 1'b0; d_cmp = 1'b0; d_cmps = 1'b0; d_mem = 1'b0; d_trap = 1'b0;
		d_pre = 1'b0; d_post = 1'b0; d_svc = 1'b0; d_retint = 1'b0; d_mtms = 1'b0;
		d_ibar = 1'b0; d_mfms = 1'b0; d_fp = 1'b0; d_zra = 1'b0;
		case (op6)
			`INSD_OP_TWI:    begin d_trap = 1'b1; d_bsel = 2'd1; end
			`INSD_OP_MULLI:  begin d_arith = 1'b1; d_alu = ALU_MULLW; d_bsel = 2'd1; end
			`INSD_OP_SUBFIC: begin
				d_arith = 1'b1; d_alu = ALU_SUBF; d_bsel = 2'd1; d_setca = 1'b1; // RQ20
			end
			`INSD_OP_CMPLI:  begin d_cmp = 1'b1; d_bsel = 2'd3; end // RQ21
			`INSD_OP_CMPI:   begin d_cmp = 1'b1; d_cmps = 1'b1; d_bsel = 2'd1; end // RQ21
			`INSD_OP_ADDIC:  begin d_arith = 1'b1; d_bsel = 2'd1; d_setca = 1'b1; end
			`INSD_OP_ADDICR: begin
				d_arith = 1'b1; d_bsel = 2'd1; d_setca = 1'b1; d_rc = 1'b1; // RQ18
			end
			`INSD_OP_ADDI:   begin d_arith = 1'b1; d_bsel = 2'd1; d_zra = 1'b1; end
			`INSD_OP_ADDIS:  begin d_arith = 1'b1; d_bsel = 2'd2; d_zra = 1'b1; end
			`INSD_OP_SVC:    begin d_svc = 1'b1; d_pre = 1'b1; end // RQ1
			`INSD_OP_GRP19: begin
				if (xo10 == `INSD_XO_RETINT) begin
					d_retint = 1'b1; d_priv = 1'b1; d_pre = 1'b1; // RQ1 RQ10
				end else if (xo10 == `INSD_XO_IBAR) begin
					d_ibar = 1'b1; d_post = 1'b1; // RQ6
				end else begin
					d_ill = 1'b1;
				end
			end
			`INSD_OP_GRP31: begin
				case (xo10)
					`INSD_XO_CMP:     begin d_cmp = 1'b1; d_cmps = 1'b1; end // RQ21
					`INSD_XO_CMPL:    d_cmp = 1'b1;
					`INSD_XO_TW:      d_trap = 1'b1;
					`INSD_XO_MF_MS:   begin d_priv = 1'b1; d_mfms = 1'b1; end
					`INSD_XO_MT_MS:   begin d_priv = 1'b1; d_mtms = 1'b1; d_pre = 1'b1; end // RQ7
					`INSD_XO_MF_SPEC, `INSD_XO_MT_SPEC:
						d_priv = insn_q[`INSD_SPECIAL_PRIV]; // RQ11
					`INSD_XO_MF_SEG, `INSD_XO_MF_SEGI, `INSD_XO_MT_SEG, `INSD_XO_MT_SEGI,
					`INSD_XO_DCINV, `INSD_XO_TLBINV, `INSD_XO_TLBSYN, `INSD_XO_TLBLDD,
					`INSD_XO_TLBLDI:  d_priv = 1'b1; // RQ10
					`INSD_XO_MBAR:    d_post = 1'b1; // RQ6
					default: begin
						d_arith = 1'b1;
						d_oe    = insn_q[10];
						d_rc    = insn_q[0];
						case (xo9)
							`INSD_XO_ADD:    d_alu = ALU_ADD;
							`INSD_XO_ADDC:   begin d_alu = ALU_ADD; d_setca = 1'b1; end
							`INSD_XO_ADDE:   begin d_alu = ALU_ADDE; d_setca = 1'b1; end
							`INSD_XO_ADDME:  begin d_alu = ALU_ADDME; d_setca = 1'b1; end
							`INSD_XO_ADDZE:  begin d_alu = ALU_ADDZE; d_setca = 1'b1; end
							`INSD_XO_DIVW:   d_alu = ALU_DIVW;
							`INSD_XO_DIVWU:  d_alu = ALU_DIVWU;
							`INSD_XO_MULHW:  begin d_alu = ALU_MULHW; d_oe = 1'b0; end
							`INSD_XO_MULHWU: begin d_alu = ALU_MULHWU; d_oe = 1'b0; end
							`INSD_XO_MULLW:  d_alu = ALU_MULLW;
							`INSD_XO_NEG:    d_alu = ALU_NEG;
							`INSD_XO_SUBF:   d_alu = ALU_SUBF; // RQ20
							`INSD_XO_SUBFC:  begin d_alu = ALU_SUBF; d_setca = 1'b1; end
							`INSD_XO_SUBFE:  begin d_alu = ALU_SUBFE; d_setca = 1'b1; end
							`INSD_XO_SUBFME: begin d_alu = ALU_SUBFME; d_setca = 1'b1; end
							`INSD_XO_SUBFZE: begin d_alu = ALU_SUBFZE; d_setca = 1'b1; end
							default: begin d_ill = 1'b1; d_arith = 1'b0; end // RQ9
						endcase
					end
				endcase
			end
			`INSD_OP_LWZ, `INSD_OP_STW: begin d_mem = 1'b1; d_size = 2'd2; d_zra = 1'b1; end
			`INSD_OP_LHZ, `INSD_OP_STH: begin d_mem = 1'b1; d_size = 2'd1; d_zra = 1'b1; end
			`INSD_OP_LBZ, `INSD_OP_STB: begin d_mem = 1'b1; d_zra = 1'b1; end
			default: begin
				d_fp  = is_fp;
				d_ill = !is_fp; // RQ9
			end
		endcase
	end

	// Operand B, effective address, alignment and trap condition
	always_comb begin
		case (d_bsel)
			2'd1:    opnd_b = simm;
			2'd2:    opnd_b = {insn_q[15:0], 16'h0000};
			2'd3:    opnd_b = {16'h0000, insn_q[15:0]};
			default: opnd_b = opb_q;
		endcase
	end
	assign ea       = base_a + simm;
	assign misalign = (d_size == 2'd2 && ea[1:0] != 2'h0) ||
	                  (d_size == 2'd1 && ea[0]); // RQ13
	assign trap_hit = (insn_q[25] && $signed(opa_q) < $signed(opnd_b)) ||
	                  (insn_q[24] && $signed(opa_q) > $signed(opnd_b)) ||
	                  (insn_q[23] && opa_q == opnd_b) ||
	                  (insn_q[22] && opa_q < opnd_b) ||
	                  (insn_q[21] && opa_q > opnd_b);

	// Exception class in priority order
	always_comb begin
		if (d_ill)
			d_cls = EXC_ILLEG; // RQ9
		else if (d_priv && user_mode_bit)
			d_cls = EXC_PRIV; // RQ10
		else if (d_fp && !machine_state_reg_q[`INSD_MS_FPAV])
			d_cls = EXC_FPUNAV; // RQ16
		else if (d_fp && fp_exc_raised && (machine_state_reg_q[`INSD_MS_FE0] ||
		         machine_state_reg_q[`INSD_MS_FE1]))
			d_cls = EXC_FPPROG; // RQ17
		else if (d_mem && page_fault)
			d_cls = EXC_IAFLT; // RQ12
		else if (d_mem && misalign)
			d_cls = EXC_ALIGN; // RQ13
		else if (d_trap && trap_hit)
			d_cls = EXC_TRAP; // RQ15
		else if (d_svc)
			d_cls = EXC_SVC; // RQ14
		else
			d_cls = EXC_NONE;
	end

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	insd_alu u_alu (
		.op    (d_alu),
		.a     (base_a),
		.b     (opnd_b),
		.ca_in (integer_exception_reg_q[`INSD_IE_CA]),
		.res   (alu_res),
		.ca    (alu_ca),
		.ov    (alu_ov)
	); // RQ23

	assign so_next = integer_exception_reg_q[`INSD_IE_SO] || (d_oe && alu_ov);

	insd_cmp u_cmp (
		.a          (opa_q),
		.b          (opnd_b),
		.signed_cmp (d_cmps),
		.so         (integer_exception_reg_q[`INSD_IE_SO]),
		.field      (cmp_field)
	);

	insd_cmp u_rec (
		.a          (alu_res),
		.b          (32'h0000_0000),
		.signed_cmp (1'b1),
		.so         (so_next),
		.field      (rec_field)
	);

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	assign drained = !older_busy && !dstore_err_pend && !(d_svc && hi_prio_pend); // RQ2 RQ3
	assign apply   = (state_q == ST_EXEC) && (d_cls == EXC_NONE || d_cls == EXC_SVC);

	// Issue, drain before, execute, drain after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE:
					if (wr_go && paddr == `INSD_OFF_INSN)
						state_q <= ST_DRAIN;
				ST_DRAIN:
					if (!d_pre || drained)
						state_q <= ST_EXEC; // RQ1 RQ3 RQ4 RQ7
				ST_EXEC:
					state_q <= d_post ? ST_POST : ST_IDLE;
				ST_POST:
					if (!older_busy)
						state_q <= ST_IDLE; // RQ6
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Held instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			insn_q <= `INSD_RST_WORD;
		else if (wr_go && paddr == `INSD_OFF_INSN && state_q == ST_IDLE)
			insn_q <= pwdata;
	end

	// Exception report and context switch pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_valid <= 1'b0;
			exc_class <= EXC_NONE;
			ctx_sync  <= 1'b0;
		end else begin
			exc_valid <= (state_q == ST_EXEC) && (d_cls != EXC_NONE);
			ctx_sync  <= apply && (d_svc || d_retint); // RQ5
			if (state_q == ST_EXEC)
				exc_class <= d_cls;
		end
	end

	// Machine state and enforced privilege
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			machine_state_reg_q <= `INSD_RST_WORD;
			user_mode_bit       <= 1'b0;
		end else begin
			if (wr_go && paddr == `INSD_OFF_MSTATE)
				machine_state_reg_q <= pwdata;
			if (apply && (d_mtms || d_retint))
				machine_state_reg_q <= opa_q; // RQ7
			if (apply && d_retint)
				user_mode_bit <= opa_q[`INSD_MS_USER]; // RQ5
			else if (state_q == ST_POST && d_ibar && !older_busy)
				user_mode_bit <= machine_state_reg_q[`INSD_MS_USER]; // RQ8
		end
	end

	// Result, exception and condition register updates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q                <= `INSD_RST_WORD;
			integer_exception_reg_q <= `INSD_RST_WORD;
			condition_reg_q         <= `INSD_RST_WORD;
		end else begin
			if (wr_go && paddr == `INSD_OFF_INTEXC)
				integer_exception_reg_q <= pwdata;
			if (wr_go && paddr == `INSD_OFF_COND)
				condition_reg_q <= pwdata;
			if (apply && d_mfms)
				result_q <= machine_state_reg_q;
			if (apply && d_mem)
				result_q <= ea;
			if (apply && d_arith) begin
				result_q <= alu_res;
				if (d_setca)
					integer_exception_reg_q[`INSD_IE_CA] <= alu_ca;
				if (d_oe) begin
					integer_exception_reg_q[`INSD_IE_OV] <= alu_ov; // RQ19
					integer_exception_reg_q[`INSD_IE_SO] <= so_next; // RQ19
				end
				if (d_rc)
					condition_reg_q[31:28] <= rec_field; // RQ18
			end
			if (apply && d_cmp)
				condition_reg_q[31 - 4 * tgt_fld -: 4] <= cmp_field; // RQ22
		end
	end
endmodule

// ==== src/insd_defines.svh ====
// Block constants: register offsets, fields, opcodes.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef INSD_DEFINES_SVH
`define INSD_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define INSD_OFF_INSN    8'h00
`define INSD_OFF_OPA     8'h04
`define INSD_OFF_OPB     8'h08
`define INSD_OFF_MSTATE  8'h0C
`define INSD_OFF_INTEXC  8'h10
`define INSD_OFF_COND    8'h14
`define INSD_OFF_RESULT  8'h18
`define INSD_OFF_STATUS  8'h1C
// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define INSD_RST_WORD    32'h0000_0000
`define INSD_MS_FE1      8
`define INSD_MS_FE0      11
`define INSD_MS_FPAV     13
`define INSD_MS_USER     14
`define INSD_IE_SO       31
`define INSD_IE_OV       30
`define INSD_IE_CA       29
`define INSD_SPECIAL_PRIV 15
// ----------------------------------------------------------------
// Primary opcodes
// ----------------------------------------------------------------
`define INSD_OP_TWI      6'h03
`define INSD_OP_MULLI    6'h07
`define INSD_OP_SUBFIC   6'h08
`define INSD_OP_CMPLI    6'h0A
`define INSD_OP_CMPI     6'h0B
`define INSD_OP_ADDIC    6'h0C
`define INSD_OP_ADDICR   6'h0D
`define INSD_OP_ADDI     6'h0E
`define INSD_OP_ADDIS    6'h0F
`define INSD_OP_SVC      6'h11
`define INSD_OP_GRP19    6'h13
`define INSD_OP_GRP31    6'h1F
`define INSD_OP_LWZ      6'h20
`define INSD_OP_LBZ      6'h22
`define INSD_OP_STW      6'h24
`define INSD_OP_STB      6'h26
`define INSD_OP_LHZ      6'h28
`define INSD_OP_STH      6'h2C
`define INSD_OP_FPS      6'h3B
`define INSD_OP_FPD      6'h3F
`define INSD_OP_FPM_LO   6'h30
`define INSD_OP_FPM_HI   6'h37
// ----------------------------------------------------------------
// Extended opcodes, ten-bit
// ----------------------------------------------------------------
`define INSD_XO_RETINT   10'h032
`define INSD_XO_IBAR     10'h096
`define INSD_XO_CMP      10'h000
`define INSD_XO_CMPL     10'h020
`define INSD_XO_TW       10'h004
`define INSD_XO_MF_MS    10'h053
`define INSD_XO_MT_MS    10'h092
`define INSD_XO_MF_SPEC  10'h153
`define INSD_XO_MT_SPEC  10'h1D3
`define INSD_XO_MF_SEG   10'h253
`define INSD_XO_MF_SEGI  10'h293
`define INSD_XO_MT_SEG   10'h0D2
`define INSD_XO_MT_SEGI  10'h0F2
`define INSD_XO_DCINV    10'h1D6
`define INSD_XO_TLBINV   10'h132
`define INSD_XO_TLBSYN   10'h236
`define INSD_XO_TLBLDD   10'h3D2
`define INSD_XO_TLBLDI   10'h3F2
`define INSD_XO_MBAR     10'h256
// ----------------------------------------------------------------
// Extended opcodes, nine-bit arithmetic
// ----------------------------------------------------------------
`define INSD_XO_ADD      9'h10A
`define INSD_XO_ADDC     9'h00A
`define INSD_XO_ADDE     9'h08A
`define INSD_XO_ADDME    9'h0EA
`define INSD_XO_ADDZE    9'h0CA
`define INSD_XO_DIVW     9'h1EB
`define INSD_XO_DIVWU    9'h1CB
`define INSD_XO_MULHW    9'h04B
`define INSD_XO_MULHWU   9'h00B
`define INSD_XO_MULLW    9'h0EB
`define INSD_XO_NEG      9'h068
`define INSD_XO_SUBF     9'h028
`define INSD_XO_SUBFC    9'h008
`define INSD_XO_SUBFE    9'h088
`define INSD_XO_SUBFME   9'h0E8
`define INSD_XO_SUBFZE   9'h0C8
`endif

// ==== src/insd_pkg.sv ====
// Types of the instruction decode and sync block.
// Assumes the defines header sits beside it.
package insd_pkg;
	typedef enum logic [3:0] {
		EXC_NONE   = 4'h0,
		EXC_ILLEG  = 4'h1,
		EXC_PRIV   = 4'h2,
		EXC_IAFLT  = 4'h3,
		EXC_ALIGN  = 4'h4,
		EXC_SVC    = 4'h5,
		EXC_TRAP   = 4'h6,
		EXC_FPUNAV = 4'h7,
		EXC_FPPROG = 4'h8
	} insd_exc_e;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_DRAIN = 4'h2,
		ST_EXEC  = 4'h4,
		ST_POST  = 4'h8
	} insd_state_e;
	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADDE, ALU_ADDME, ALU_ADDZE, ALU_SUBF, ALU_SUBFE, ALU_SUBFME,
		ALU_SUBFZE, ALU_NEG, ALU_MULHW, ALU_MULHWU, ALU_MULLW, ALU_DIVW, ALU_DIVWU
	} insd_alu_e;
endpackage

// ==== src/insd_alu.sv ====
// Integer arithmetic: add, subtract-from, multiply, divide, negate.
// Assumes the decoder selects operands; combinational.
`timescale 1ns/1ps
module insd_alu import insd_pkg::*; (
	input  wire insd_alu_e   op,
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	input  wire logic        ca_in,
	output logic      [31:0] res,
	output logic             ca,
	output logic             ov
);
	logic [31:0] x;
	logic [31:0] y;
	logic        c;
	logic [32:0] sum;
	logic [63:0] prod_s;
	logic [63:0] prod_u;

	// Adder operand shaping; subtract-from is not a plus b plus one
	always_comb begin
		x = a;
		y = b;
		c = 1'b0;
		case (op)
			ALU_ADDE:   c = ca_in;
			ALU_ADDME:  begin y = 32'hFFFF_FFFF; c = ca_in; end
			ALU_ADDZE:  begin y = 32'h0000_0000; c = ca_in; end
			ALU_SUBF:   begin x = ~a; c = 1'b1; end
			ALU_SUBFE:  begin x = ~a; c = ca_in; end
			ALU_SUBFME: begin x = ~a; y = 32'hFFFF_FFFF; c = ca_in; end
			ALU_SUBFZE: begin x = ~a; y = 32'h0000_0000; c = ca_in; end
			ALU_NEG:    begin x = ~a; y = 32'h0000_0000; c = 1'b1; end
			default:    c = 1'b0;
		endcase
	end

	assign sum    = {1'b0, x} + {1'b0, y} + {32'h0000_0000, c};
	assign prod_s = 64'($signed(a) * $signed(b));
	assign prod_u = {32'h0000_0000, a} * {32'h0000_0000, b};

	// Result, carry and overflow per operation
	always_comb begin
		res = sum[31:0];
		ca  = sum[32];
		ov  = (x[31] == y[31]) && (sum[31] != x[31]);
		case (op)
			ALU_MULHW:  begin res = prod_s[63:32]; ov = 1'b0; end
			ALU_MULHWU: begin res = prod_u[63:32]; ov = 1'b0; end
			ALU_MULLW: begin
				res = prod_s[31:0];
				ov  = (prod_s[63:32] != {32{prod_s[31]}});
			end
			ALU_DIVW: begin
				ov  = (b == 32'h0000_0000) ||
				      (a == 32'h8000_0000 && b == 32'hFFFF_FFFF);
				res = ov ? 32'h0000_0000 : 32'($signed(a) / $signed(b));
			end
			ALU_DIVWU: begin
				ov  = (b == 32'h0000_0000);
				res = ov ? 32'h0000_0000 : a / b;
			end
			default: res = sum[31:0];
		endcase
	end
endmodule

// ==== src/insd_cmp.sv ====
// Four-bit condition field from a signed or unsigned comparison.
// Assumes the caller supplies summary overflow; combinational.
`timescale 1ns/1ps
module insd_cmp (
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	input  wire logic        signed_cmp,
	input  wire logic        so,
	output logic      [3:0]  field
);
	logic lt;

	// Less-than, greater-than, equal, summary overflow
	assign lt    = signed_cmp ? ($signed(a) < $signed(b)) : (a < b);
	assign field = {lt, !lt && (a != b), a == b, so};
endmodule

// ==== test/insd_partner.sv ====
// Far-side model: older-work busy window and fault lines.
// Assumes one-cycle go pulses from the bench.
`timescale 1ns/1ps
module insd_partner (
	input  wire logic       pclk, presetn, go,
	input  wire logic [3:0] len, flt,
	output logic            older_busy, dstore_err_pend, hi_prio_pend, page_fault, fp_exc_raised
);
	logic [3:0] cnt_q;
	// Busy countdown loaded by go
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt_q <= 4'h0;
		else if (go) cnt_q <= len;
		else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
	end
	// Pending cause picked by flt; flt[3:2] both set raises two at once
	assign older_busy      = cnt_q != 4'h0 && flt[3:2] == 2'b00;
	assign dstore_err_pend = cnt_q != 4'h0 && flt[3];
	assign hi_prio_pend    = cnt_q != 4'h0 && flt[2];
	assign page_fault      = flt[1];
	assign fp_exc_raised   = flt[0];
endmodule

// ==== test/insd_core_checker.sv ====
// Checker: handshake and exception relations at the block ports.
// Assumes it is bound onto insd_core.
`timescale 1ns/1ps
`include "insd_defines.svh"
module insd_core_checker import insd_pkg::*; (
	input wire logic       pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [7:0] paddr,
	input wire logic       older_busy, dstore_err_pend, hi_prio_pend, page_fault, fp_exc_raised,
	input wire logic       exc_valid, ctx_sync, user_mode_bit,
	input wire logic [3:0] exc_class
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("ready late");
	property p_ro; pready && pwrite && paddr == `INSD_OFF_RESULT |-> pslverr; endproperty
	a_ro: assert property (p_ro) else $error("ro write taken");
	property p_sync; ctx_sync |-> !$past(older_busy, 2) && !$past(dstore_err_pend, 2); endproperty
	a_sync: assert property (p_sync) else $error("early switch");
	property p_prio; ctx_sync && exc_class == EXC_SVC |-> !$past(hi_prio_pend, 2); endproperty
	a_prio: assert property (p_prio) else $error("call over pending");
	property p_svc; exc_valid && exc_class == EXC_SVC |-> ctx_sync ##1 !ctx_sync; endproperty
	a_svc: assert property (p_svc) else $error("call no switch");
	property p_priv; exc_valid && exc_class == EXC_PRIV |-> user_mode_bit; endproperty
	a_priv: assert property (p_priv) else $error("priv in supervisor");
	property p_pf; exc_valid && exc_class == EXC_IAFLT |-> $past(page_fault); endproperty
	a_pf: assert property (p_pf) else $error("fault no cause");
	property p_fpx; exc_valid && exc_class == EXC_FPPROG |-> $past(fp_exc_raised); endproperty
	a_fpx: assert property (p_fpx) else $error("fp prog no cause");
endmodule
bind insd_core insd_core_checker u_chk (.*);

// ==== test/insd_core_tb.sv ====
// Bench: APB stimulus, far-side model, result and class checks.
// Assumes design, partner and checker compiled before it.
`timescale 1ns/1ps
`include "insd_defines.svh"
module insd_core_tb import insd_pkg::*; ();
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] len = 4'h0, flt = 4'h0, exc_class;
	logic pready, pslverr, older_busy, dstore_err_pend, hi_prio_pend, page_fault, fp_exc_raised;
	logic exc_valid, ctx_sync, user_mode_bit, err;
	int errors = 0, samples_checked = 0;
	always #5 pclk = ~pclk;
	insd_partner u_far (.*);
	insd_core dut (.*);
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; holds until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin errors++; final_report(); end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Issue one instruction, poll busy, compare the class
	task automatic rc(input logic [31:0] i, input insd_exc_e e,
		input logic [3:0] l = 4'h0, f = 4'h0);
		@(posedge pclk);
		go <= 1'b1;
		len <= l;
		flt <= f;
		@(posedge pclk);
		go <= 1'b0;
		apb(1'b1, `INSD_OFF_INSN, i);
		rd = 32'h100;
		for (int k = 0; k < 30 && rd[8] !== 1'b0; k++) apb(1'b0, `INSD_OFF_STATUS, 32'h0);
		if (rd[8] !== 1'b0) begin errors++; final_report(); end
		chk({28'h0, rd[3:0]}, {28'h0, e});
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_arith();
		apb(1'b1, `INSD_OFF_OPA, 32'h0000_0003);
		apb(1'b1, `INSD_OFF_OPB, 32'h0000_000A);
		rc(32'h7C00_0051, EXC_NONE);
		rchk(`INSD_OFF_RESULT, 32'h0000_0007);
		rchk(`INSD_OFF_COND, 32'h4000_0000);
		apb(1'b1, `INSD_OFF_OPA, 32'h0000_0001);
		apb(1'b1, `INSD_OFF_OPB, 32'h8000_0000);
		rc(32'h7C00_0450, EXC_NONE);
		rchk(`INSD_OFF_RESULT, 32'h7FFF_FFFF);
		rchk(`INSD_OFF_INTEXC, 32'hC000_0000);
		rchk(`INSD_OFF_COND, 32'h4000_0000);
		apb(1'b1, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task automatic s_cmp();
		apb(1'b1, `INSD_OFF_COND, 32'h0);
		apb(1'b1, `INSD_OFF_OPA, 32'hFFFF_FFFF);
		apb(1'b1, `INSD_OFF_OPB, 32'h0000_0001);
		rc(32'h7D80_0000, EXC_NONE);
		rchk(`INSD_OFF_COND, 32'h0009_0000);
		rc(32'h7C00_0040, EXC_NONE);
		rchk(`INSD_OFF_COND, 32'h5009_0000);
	endtask
	task automatic s_priv();
		apb(1'b1, `INSD_OFF_MSTATE, 32'h0000_4000);
		rc(32'h7C00_00A6, EXC_NONE, 4'h6, 4'h0);
		rchk(`INSD_OFF_RESULT, 32'h0000_4000);
		rc(32'h4C00_012C, EXC_NONE, 4'h6, 4'h0);
		chk({31'h0, user_mode_bit}, 32'h1);
		rc(32'h7C00_03A6, EXC_NONE);
		rc(32'h7C00_83A6, EXC_PRIV);
		rc(32'h7C00_00A6, EXC_PRIV);
	endtask
	task automatic s_exc();
		rchk(`INSD_OFF_MSTATE, 32'h0);
		apb(1'b1, `INSD_OFF_OPA, 32'h0000_0002);
		rc(32'h0, EXC_ILLEG);
		rc(32'h8000_0000, EXC_IAFLT, 4'h0, 4'h2);
		rc(32'h8001_0000, EXC_ALIGN);
		rc(32'h7FE0_0008, EXC_TRAP);
		rc(32'h4400_0002, EXC_SVC, 4'hC, 4'h4);
		rc(32'h4400_0002, EXC_SVC, 4'hC, 4'h8);
		rc(32'h4400_0002, EXC_SVC, 4'hC, 4'h0);
		rc(32'hFC00_0000, EXC_FPUNAV);
		apb(1'b1, `INSD_OFF_MSTATE, 32'h0000_2800);
		rc(32'hFC00_0000, EXC_FPPROG, 4'h0, 4'h1);
		apb(1'b1, `INSD_OFF_OPA, 32'h0000_4000);
		rc(32'h4C00_0064, EXC_NONE, 4'h6, 4'h0);
		chk({31'h0, user_mode_bit}, 32'h1);
	endtask
	// Main sequence, with a second reset to leave user mode
	initial begin
		do_reset();
		s_arith();
		s_cmp();
		s_priv();
		do_reset();
		s_exc();
		final_report();
	end
endmodule
